/* File: verilog/vcofc_cfg.svh */
// register map, field positions, reset values and down-sampling rates of the voltage output filter control
//
// Notes on behaviour
// - output-control bit 4 masks the data-ready interrupt
// - output-control bits 3:2 pick the output stage
// - filter-control bit 7 picks FIR or mean
// - filter-control bits 6:3 set mean sample count
// - indices 0x19 to 0x2C ignore every write
// - decimation-control bits 4:1 set second-stage ratio
// - decimation-control bit 7 picks first-stage rate
`ifndef VCOFC_CFG_SVH
`define VCOFC_CFG_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define VCOFC_IDX_DECIM     8'h45
`define VCOFC_IDX_OUTSEL    8'h46
`define VCOFC_IDX_FINAL     8'h47
`define VCOFC_IDX_RO_LO     8'h19
`define VCOFC_IDX_RO_HI     8'h2C
`define VCOFC_IDX_WORD_LO   8'h19
`define VCOFC_IDX_WORD_HI   8'h1A
`define VCOFC_IDX_IRQ_STAT  8'h60
`define VCOFC_IDX_IRQ_EN    8'h61

// ****************************************
// reset values and writable-bit masks
// ****************************************
`define VCOFC_RST_DECIM     8'h45
`define VCOFC_RST_OUTSEL    8'h04
`define VCOFC_RST_FINAL     8'h00
`define VCOFC_WMASK_DECIM   8'hFF
`define VCOFC_WMASK_OUTSEL  8'h1C
`define VCOFC_WMASK_FINAL   8'hF8

// ****************************************
// field positions
// ****************************************
`define VCOFC_DRDY_MASK_BIT 4
`define VCOFC_SRC_MSB       3
`define VCOFC_SRC_LSB       2
`define VCOFC_MEAN_SEL_BIT  7
`define VCOFC_MEAN_CNT_MSB  6
`define VCOFC_MEAN_CNT_LSB  3
`define VCOFC_RATE_BIT      7
`define VCOFC_CHOP_MSB      6
`define VCOFC_CHOP_LSB      5
`define VCOFC_SECOND_COMB_INTEGRATOR_STAGE_MSB      4
`define VCOFC_SECOND_COMB_INTEGRATOR_STAGE_LSB      1
`define VCOFC_SAT_MASK_BIT  0

// ****************************************
// first-stage down-sampling rates
// ****************************************
`define VCOFC_DSR_LOW       8'h40
`define VCOFC_DSR_HIGH      8'h80

`endif

/* File: verilog/vcofc_pkg.sv */
// types shared by the voltage output filter control block
`default_nettype none
package vcofc_pkg;

  // output stage codes
  typedef enum logic [1:0] {
    VCOFC_SRC_FINAL  = 2'h0,
    VCOFC_SRC_SECOND_COMB_INTEGRATOR_STAGE   = 2'h1,
    VCOFC_SRC_DECHOP = 2'h2,
    VCOFC_SRC_CIC1   = 2'h3
  } vcofc_src_t;

  // one sample of each stage of the chain
  typedef struct packed {
    logic [15:0] fir;
    logic [15:0] second_comb_integrator_stage;
    logic [15:0] dechop;
    logic [15:0] cic1;
  } vcofc_stage_t;

  // decoded settings driven to the filter chain
  typedef struct packed {
    logic [7:0]  cic1_ratio;
    logic [15:0] second_comb_integrator_stage_ratio;
    logic [1:0]  chop_div;
    logic        sat_mask;
  } vcofc_chain_t;

endpackage
`default_nettype wire

/* File: verilog/vcofc_top.sv */
// ahb-lite register slave, output stage selection and running mean of the voltage channel
`timescale 1ns/1ps
`default_nettype none
`include "vcofc_cfg.svh"

module vcofc_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  input  wire vcofc_pkg::vcofc_stage_t stage_in,
  input  wire logic                  stage_valid,
  output logic      [15:0]           out_word,
  output logic                       out_valid,
  output vcofc_pkg::vcofc_chain_t    chain_cfg,
  output logic                       irq
);

  // ****************************************
  // bus slave
  // ****************************************
  logic        dp_wr, next_dp_wr;          // write data phase pending
  logic [7:0]  dp_idx, next_dp_idx;        // register index of data phase
  logic [31:0] rdata, next_rdata;          // registered read data
  logic [7:0]  r_decim, next_r_decim;      // decimation control
  logic [7:0]  r_outsel, next_r_outsel;    // output select control
  logic [7:0]  r_final, next_r_final;      // final filter control
  logic        irq_stat, next_irq_stat;    // sticky data-ready status
  logic        irq_en, next_irq_en;        // interrupt enable
  logic        addr_ok;                    // valid address phase
  logic [7:0]  a_idx;                      // index of address phase

  assign addr_ok   = hsel && hready && htrans[1];
  assign a_idx     = haddr[9:2];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata;

  // next register and bus values
  always_comb begin
    next_dp_wr    = addr_ok && hwrite;
    next_dp_idx   = addr_ok ? a_idx : dp_idx;
    next_rdata    = rdata;
    next_r_decim  = r_decim;
    next_r_outsel = r_outsel;
    next_r_final  = r_final;
    next_irq_en   = irq_en;
    // set beats the write-one clear
    next_irq_stat = irq_stat;
    // write data phase; read-only window and reserved bits untouched
    if (dp_wr) begin
      if (dp_idx >= `VCOFC_IDX_RO_LO && dp_idx <= `VCOFC_IDX_RO_HI) begin
        next_r_decim = r_decim;
      end else if (dp_idx == `VCOFC_IDX_DECIM) begin
        next_r_decim = hwdata[7:0] & `VCOFC_WMASK_DECIM;
      end else if (dp_idx == `VCOFC_IDX_OUTSEL) begin
        next_r_outsel = hwdata[7:0] & `VCOFC_WMASK_OUTSEL;
      end else if (dp_idx == `VCOFC_IDX_FINAL) begin
        next_r_final = hwdata[7:0] & `VCOFC_WMASK_FINAL;
      end else if (dp_idx == `VCOFC_IDX_IRQ_STAT) begin
        if (hwdata[0]) begin
          next_irq_stat = 1'b0;
        end
      end else if (dp_idx == `VCOFC_IDX_IRQ_EN) begin
        next_irq_en = hwdata[0];
      end
    end
    if (out_valid) begin
      next_irq_stat = 1'b1;
    end
    // read data captured at the address phase
    if (addr_ok && !hwrite) begin
      if (a_idx == `VCOFC_IDX_DECIM) begin
        next_rdata = {24'h00_0000, r_decim};
      end else if (a_idx == `VCOFC_IDX_OUTSEL) begin
        next_rdata = {24'h00_0000, r_outsel};
      end else if (a_idx == `VCOFC_IDX_FINAL) begin
        next_rdata = {24'h00_0000, r_final};
      end else if (a_idx == `VCOFC_IDX_WORD_LO) begin
        next_rdata = {24'h00_0000, out_word[7:0]};
      end else if (a_idx == `VCOFC_IDX_WORD_HI) begin
        next_rdata = {24'h00_0000, out_word[15:8]};
      end else if (a_idx == `VCOFC_IDX_IRQ_STAT) begin
        next_rdata = {31'h0000_0000, irq_stat};
      end else if (a_idx == `VCOFC_IDX_IRQ_EN) begin
        next_rdata = {31'h0000_0000, irq_en};
      end else begin
        next_rdata = 32'h0000_0000;
      end
    end
  end

  // register bus state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr    <= 1'b0;
      dp_idx   <= 8'h00;
      rdata    <= 32'h0000_0000;
      r_decim  <= `VCOFC_RST_DECIM;
      r_outsel <= `VCOFC_RST_OUTSEL;
      r_final  <= `VCOFC_RST_FINAL;
      irq_stat <= 1'b0;
      irq_en   <= 1'b0;
    end else begin
      dp_wr    <= next_dp_wr;
      dp_idx   <= next_dp_idx;
      rdata    <= next_rdata;
      r_decim  <= next_r_decim;
      r_outsel <= next_r_outsel;
      r_final  <= next_r_final;
      irq_stat <= next_irq_stat;
      irq_en   <= next_irq_en;
    end
  end

  // ****************************************
  // chain settings
  // ****************************************
  logic [3:0] second_comb_integrator_stage_code;  // second-stage ratio code
  assign second_comb_integrator_stage_code = r_decim[`VCOFC_SECOND_COMB_INTEGRATOR_STAGE_MSB:`VCOFC_SECOND_COMB_INTEGRATOR_STAGE_LSB];
  // decoded chain settings; one process drives the whole struct
  always_comb begin
    chain_cfg.cic1_ratio = r_decim[`VCOFC_RATE_BIT] ? `VCOFC_DSR_HIGH
                                                    : `VCOFC_DSR_LOW;
    chain_cfg.second_comb_integrator_stage_ratio = 16'h0001 << second_comb_integrator_stage_code;
    chain_cfg.chop_div   = r_decim[`VCOFC_CHOP_MSB:`VCOFC_CHOP_LSB];
    chain_cfg.sat_mask   = r_decim[`VCOFC_SAT_MASK_BIT];
  end

  // ****************************************
  // running mean filter
  // ****************************************
  logic [3:0]  mean_code;           // mean sample count code
  logic [2:0]  mean_shift;          // number of set bits in mean_code, used as shift
  logic [19:0] acc, next_acc;       // sample accumulator
  logic [3:0]  cnt, next_cnt;       // samples taken so far
  logic [15:0] mean, next_mean;     // last mean
  logic        mean_v, next_mean_v; // mean ready pulse
  logic [19:0] sum;                 // accumulator plus new sample

  assign mean_code  = r_final[`VCOFC_MEAN_CNT_MSB:`VCOFC_MEAN_CNT_LSB];
  assign mean_shift = 3'(mean_code[0]) + 3'(mean_code[1]) + 3'(mean_code[2])
                    + 3'(mean_code[3]);
  assign sum        = acc + {{4{stage_in.fir[15]}}, stage_in.fir};

  // accumulate a block, then shift down
  always_comb begin
    next_acc    = acc;
    next_cnt    = cnt;
    next_mean   = mean;
    next_mean_v = 1'b0;
    if (stage_valid) begin
      if (mean_code == 4'h0) begin
        next_mean   = stage_in.fir;
        next_mean_v = 1'b1;
      end else if (cnt == mean_code) begin
        next_mean   = 16'($signed(sum) >>> mean_shift);
        next_mean_v = 1'b1;
        next_acc    = 20'h0_0000;
        next_cnt    = 4'h0;
      end else begin
        next_acc = sum;
        next_cnt = cnt + 4'h1;
      end
    end
  end

  // mean filter state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc    <= 20'h0_0000;
      cnt    <= 4'h0;
      mean   <= 16'h0000;
      mean_v <= 1'b0;
    end else begin
      acc    <= next_acc;
      cnt    <= next_cnt;
      mean   <= next_mean;
      mean_v <= next_mean_v;
    end
  end

  // ****************************************
  // output word and interrupt
  // ****************************************
  vcofc_pkg::vcofc_src_t src;        // selected stage
  logic        use_mean;             // mean filter chosen
  logic [15:0] next_out_word;
  logic        next_out_valid;

  assign src      = vcofc_pkg::vcofc_src_t'(r_outsel[`VCOFC_SRC_MSB:`VCOFC_SRC_LSB]);
  assign use_mean = r_final[`VCOFC_MEAN_SEL_BIT];

  // stage multiplexer
  always_comb begin
    next_out_word  = out_word;
    next_out_valid = 1'b0;
    case (src)
      vcofc_pkg::VCOFC_SRC_FINAL: begin
        if (use_mean) begin
          next_out_valid = mean_v;
          next_out_word  = mean_v ? mean : out_word;
        end else begin
          next_out_valid = stage_valid;
          next_out_word  = stage_valid ? stage_in.fir : out_word;
        end
      end
      vcofc_pkg::VCOFC_SRC_SECOND_COMB_INTEGRATOR_STAGE: begin
        next_out_valid = stage_valid;
        next_out_word  = stage_valid ? stage_in.second_comb_integrator_stage : out_word;
      end
      vcofc_pkg::VCOFC_SRC_DECHOP: begin
        next_out_valid = stage_valid;
        next_out_word  = stage_valid ? stage_in.dechop : out_word;
      end
      default: begin
        next_out_valid = stage_valid;
        next_out_word  = stage_valid ? stage_in.cic1 : out_word;
      end
    endcase
  end

  // output registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_word  <= 16'h0000;
      out_valid <= 1'b0;
    end else begin
      out_word  <= next_out_word;
      out_valid <= next_out_valid;
    end
  end

  // level interrupt, gated by the data-ready mask
  assign irq = irq_stat && irq_en && !r_outsel[`VCOFC_DRDY_MASK_BIT];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_irq_mask_gate: assert property (r_outsel[`VCOFC_DRDY_MASK_BIT] |-> !irq)
    else $error("irq high while data-ready masked");
  a_src_second_comb_integrator_stage_word: assert property (stage_valid && src == vcofc_pkg::VCOFC_SRC_SECOND_COMB_INTEGRATOR_STAGE
    ##0 $stable(r_outsel) |=> out_word == $past(stage_in.second_comb_integrator_stage))
    else $error("second_comb_integrator_stage stage not on output word");
  a_fir_word_sel: assert property (stage_valid && src == vcofc_pkg::VCOFC_SRC_FINAL
    && !use_mean |=> out_valid && out_word == $past(stage_in.fir))
    else $error("fir stage not on output word");
  a_mean_bypass: assert property (stage_valid && mean_code == 4'h0 |=> mean_v)
    else $error("bypassed mean did not pass sample");
  a_mean_block: assert property (mean_code == 4'h1 && stage_valid && cnt == 4'h0
    ##1 (!dp_wr && !stage_valid)[*1] ##1 stage_valid |=> mean_v)
    else $error("two-sample mean not produced");
  a_ro_window: assert property (dp_wr && dp_idx >= `VCOFC_IDX_RO_LO
    && dp_idx <= `VCOFC_IDX_RO_HI
    |=> $stable(r_decim) && $stable(r_outsel) && $stable(r_final))
    else $error("read-only write changed state");
  a_second_comb_integrator_stage_ratio: assert property ($onehot(chain_cfg.second_comb_integrator_stage_ratio)
    && chain_cfg.second_comb_integrator_stage_ratio[second_comb_integrator_stage_code])
    else $error("second-stage ratio wrong");
  a_cic1_rate: assert property (chain_cfg.cic1_ratio
    == (r_decim[`VCOFC_RATE_BIT] ? `VCOFC_DSR_HIGH : `VCOFC_DSR_LOW))
    else $error("first-stage rate wrong");
  a_reserved_zero: assert property ((r_outsel & ~`VCOFC_WMASK_OUTSEL) == 8'h00
    && (r_final & ~`VCOFC_WMASK_FINAL) == 8'h00)
    else $error("reserved bits not zero");

  c_mean_out: cover property (use_mean && src == vcofc_pkg::VCOFC_SRC_FINAL && out_valid);
  c_irq_fire: cover property (irq ##[1:20] !irq_stat);
  c_ro_write: cover property (dp_wr && dp_idx == 8'h19);

endmodule
`default_nettype wire

/* File: tb/vcofc_host_model.sv */
// host model: ahb-lite master doing single word register cycles
`timescale 1ns/1ps
`default_nettype none

module vcofc_host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  // ****************************************
  // bus cycles
  // ****************************************
  // idle bus at time zero
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // address phase, held until hready is seen high
  task automatic addr_phase(input logic [7:0] idx, input logic wr);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h00_0000, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
  endtask

  // single word write; data scrambled once the cycle ends
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    addr_phase(idx, 1'b1);
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    hwdata <= ~d;
  endtask

  // single word read; data taken at the closing edge
  task automatic rd(input logic [7:0] idx, output logic [31:0] d);
    addr_phase(idx, 1'b0);
    do @(posedge hclk); while (hready !== 1'b1);
    d = hrdata;
  endtask
endmodule
`default_nettype wire

/* File: tb/vcofc_tb_top.sv */
// self-checking bench of the voltage output filter control block
`timescale 1ns/1ps
`default_nettype none

module vcofc_tb_top;
  logic                   hclk;        // 25 mhz bus clock
  logic                   hresetn;     // active low reset
  logic                   hsel;        // slave select
  logic [31:0]            haddr;       // byte address
  logic [1:0]             htrans;      // transfer type
  logic                   hwrite;      // direction
  logic [2:0]             hsize;       // transfer size, whole word
  logic [31:0]            hwdata;      // write data
  logic [31:0]            hrdata;      // read data
  logic                   hreadyout;   // slave ready, fed back as hready
  logic                   hresp;       // response
  vcofc_pkg::vcofc_stage_t stage_in;   // stage samples
  logic                   stage_valid; // sample strobe
  logic [15:0]            out_word;    // selected word
  logic                   out_valid;   // data-ready pulse
  vcofc_pkg::vcofc_chain_t chain_cfg;  // decoded chain settings
  logic                   irq;         // interrupt level
  int                     fail_count = 0; // mismatches
  int                     checked = 0;    // comparisons
  int                     cyc = 0;        // timeout counter
  logic [31:0]            v;           // read scratch

  vcofc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .stage_in(stage_in),
    .stage_valid(stage_valid), .out_word(out_word), .out_valid(out_valid),
    .chain_cfg(chain_cfg), .irq(irq));
  vcofc_host_model host_u (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // ****************************************
  // helpers
  // ****************************************
  // clock toggles every half period
  always #20 hclk = ~hclk;

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one stage sample, then wait a bounded time for the result pulse
  task automatic send(input logic [63:0] s, input logic wait_out);
    @(posedge hclk);
    stage_in    <= s;
    stage_valid <= 1'b1;
    @(posedge hclk);
    stage_valid <= 1'b0;
    stage_in    <= ~s;
    #1;
    for (int i = 0; i < 8 && wait_out && out_valid !== 1'b1; i++) begin
      @(posedge hclk);
      #1;
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  // reset values of the control registers and decoded settings
  task automatic t_reset;
    host_u.rd(8'h46, v);
    chk(v, 32'h0000_0004);
    host_u.rd(8'h47, v);
    chk(v, 32'h0000_0000);
    chk({24'h00_0000, chain_cfg.cic1_ratio}, 32'h0000_0040);
    chk({16'h0000, chain_cfg.second_comb_integrator_stage_ratio}, 32'h0000_0004);
    chk({5'h00, chain_cfg}, {5'h00, 8'h40, 16'h0004, 2'h2, 1'h1});
    host_u.rd(8'h45, v);
    chk(v, 32'h0000_0045);
    $display("t_reset done");
  endtask

  // reserved bits read zero whatever is written
  task automatic t_reserved;
    host_u.wr(8'h46, 32'h0000_00e3);
    host_u.rd(8'h46, v);
    chk(v, 32'h0000_0000);
    host_u.wr(8'h47, 32'h0000_0007);
    host_u.rd(8'h47, v);
    chk(v, 32'h0000_0000);
    $display("t_reserved done");
  endtask

  // both ends of the read-only window keep their contents
  task automatic t_readonly;
    logic [31:0] lo;
    logic [31:0] hi;
    host_u.rd(8'h19, lo);
    host_u.rd(8'h2c, hi);
    host_u.wr(8'h19, ~lo);
    host_u.wr(8'h2c, ~hi);
    chk({31'h0, hresp}, 32'h0000_0000);
    host_u.rd(8'h19, v);
    chk(v, lo);
    host_u.rd(8'h2c, v);
    chk(v, hi);
    $display("t_readonly done");
  endtask

  // every source code routes its stage to the output word
  task automatic t_source;
    logic [63:0] s;
    s = 64'ha001_b002_c003_d004;
    for (int c = 0; c < 4; c++) begin
      host_u.wr(8'h46, 32'(c) << 2);
      send(s, 1'b1);
      chk({31'h0, out_valid}, 32'h0000_0001);
      chk({16'h0000, out_word}, {16'h0000, 16'(s >> (48 - 16 * c))});
    end
    $display("t_source done");
  endtask

  // interrupt raised, masked by bit 4, then cleared
  task automatic t_irq;
    host_u.wr(8'h61, 32'h0000_0001);
    host_u.wr(8'h46, 32'h0000_0004);
    host_u.wr(8'h60, 32'h0000_0001);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    send(64'h1111_2222_3333_4444, 1'b1);
    @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    host_u.rd(8'h60, v);
    chk(v, 32'h0000_0001);
    host_u.wr(8'h46, 32'h0000_0014);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    host_u.wr(8'h46, 32'h0000_0004);
    #1;
    chk({31'h0, irq}, 32'h0000_0001);
    host_u.wr(8'h60, 32'h0000_0001);
    #1;
    chk({31'h0, irq}, 32'h0000_0000);
    $display("t_irq done");
  endtask

  // running mean of two fir words, then of four, then bypass with fir again
  task automatic t_mean;
    host_u.wr(8'h46, 32'h0000_0000);
    host_u.wr(8'h47, 32'h0000_0088);
    send(64'h0010_0000_0000_0000, 1'b0);
    send(64'h0030_0000_0000_0000, 1'b1);
    chk({16'h0000, out_word}, 32'h0000_0020);
    host_u.wr(8'h47, 32'h0000_0098);
    send(64'hfff0_0000_0000_0000, 1'b0);
    send(64'hfff0_0000_0000_0000, 1'b0);
    send(64'h0004_0000_0000_0000, 1'b0);
    send(64'h0004_0000_0000_0000, 1'b1);
    chk({16'h0000, out_word}, 32'h0000_fffa);
    host_u.rd(8'h19, v);
    chk(v, 32'h0000_00fa);
    host_u.rd(8'h1a, v);
    chk(v, 32'h0000_00ff);
    host_u.wr(8'h47, 32'h0000_0000);
    send(64'h0123_0000_0000_0000, 1'b1);
    chk({16'h0000, out_word}, 32'h0000_0123);
    $display("t_mean done");
  endtask

  // highest second-stage ratio and the fast first-stage rate
  task automatic t_decim;
    host_u.wr(8'h45, 32'h0000_009e);
    #1;
    chk({16'h0000, chain_cfg.second_comb_integrator_stage_ratio}, 32'h0000_8000);
    chk({24'h00_0000, chain_cfg.cic1_ratio}, 32'h0000_0080);
    chk({5'h00, chain_cfg}, {5'h00, 8'h80, 16'h8000, 2'h0, 1'h0});
    $display("t_decim done");
  endtask

  // mid-run reset brings outputs and registers back to reset values
  task automatic t_rerun;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
    chk({16'h0000, out_word}, 32'h0000_0000);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge hclk);
    hresetn <= 1'b1;
    host_u.rd(8'h45, v);
    chk(v, 32'h0000_0045);
    host_u.rd(8'h46, v);
    chk(v, 32'h0000_0004);
    host_u.rd(8'h47, v);
    chk(v, 32'h0000_0000);
    $display("t_rerun done");
  endtask

  // ****************************************
  // main sequence and timeout
  // ****************************************
  // hang guard well above the expected run length
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc >= 3000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // reset for three cycles, then the scenarios
  initial begin
    hclk        = 1'b0;
    hresetn     = 1'b0;
    stage_in    = 64'h0000_0000_0000_0000;
    stage_valid = 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_reserved();
    t_readonly();
    t_source();
    t_irq();
    t_mean();
    t_decim();
    t_rerun();
    report_and_stop();
  end
endmodule
`default_nettype wire
